/* File: common/mra_pkg.sv */
// Constants and types for the memory request arbiter
// Function
// - Issue to 32 interleaved banks, at most one reference per 100 ns slot.
// - Central processor addresses get the relocation base added before issue.
// - Busy-bank rejects recirculate and are re-offered 300 ns later until accepted.
// - Swap halts the central processor, counters start only after halted confirms.
// - Swap address counter advances once per memory accept of current address.
// - Swap tag counter reaching 16 returns swap-complete to peripheral processors.
// - Operand address sets operand-pending and central-request, waits for empty staging.
// - Fetch address sets fetch-pending, loads only if staging empty and no operand.
// - Return jump or swap end sets suppress-increment, leaving advance gating alone.
// - Fixed priority: recirculated first, central second, peripheral last.
// - Central read blocked by write in first two stages, and vice versa.
// - During a swap ordinary peripheral reads and writes are blocked.
// - Each admitted address gets a valid bit and a go strobe to memory.
// - Queue input picks among four source paths per address bit by grant.
// - Each entering address is paired with a six-bit tag travelling with it.
// - Four queue stages of address, tag and valid; one stage lacks valid.
// - An accepted address is dropped and never re-enters the first stage.
package mra_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int SLOT_NS = 100;
  localparam int RECIRC_NS = 300;
  localparam int SLOT_CYCLES = (SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECIRC_SLOTS = RECIRC_NS / SLOT_NS;
  localparam int BANK_COUNT = 32;
  localparam int ADDR_W = 18;
  localparam int TAG_W = 6;
  localparam int SWAP_CNT_W = 5;
  localparam logic [SWAP_CNT_W-1:0] SWAP_LAST = 5'h10;
  localparam logic [SWAP_CNT_W-1:0] SWAP_TAG_RST = 5'h00;
  localparam logic [1:0] SLOT_LAST = 2'(SLOT_CYCLES - 1);
  localparam logic [1:0] SLOT_RST = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
  localparam logic [TAG_W-1:0] TAG_RST = 6'h00;
  typedef enum logic [1:0] {MRA_KIND_READ, MRA_KIND_WRITE, MRA_KIND_SWAP, MRA_KIND_NONE} mra_kind_t;
  typedef enum logic [1:0] {MRA_SW_IDLE, MRA_SW_HALT, MRA_SW_RUN} mra_swap_t;
endpackage

/* File: verilog/mra_arbiter.sv */
// Memory request arbiter with four-stage re-issue queue
`timescale 1ns/1ps
`default_nettype none
module mra_arbiter (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Central processor
  input wire logic op_req,
  input wire logic [mra_pkg::ADDR_W-1:0] op_addr,
  input wire logic [mra_pkg::TAG_W-1:0] op_tag,
  input wire logic op_write,
  input wire logic fetch_req,
  input wire logic [mra_pkg::ADDR_W-1:0] fetch_addr,
  input wire logic [mra_pkg::TAG_W-1:0] fetch_tag,
  input wire logic return_jump,
  input wire logic cpu_halted,
  input wire logic [mra_pkg::ADDR_W-1:0] relocation_base_register,
  output logic operand_pending,
  output logic fetch_pending,
  output logic central_req,
  output logic suppress_inc,
  output logic cpu_halt,
  // Peripheral processors
  input wire logic pp_req,
  input wire logic [mra_pkg::ADDR_W-1:0] pp_addr,
  input wire logic [1:0] pp_kind,
  input wire logic [mra_pkg::TAG_W-1:0] pp_tag,
  output logic pp_grant,
  output logic swap_done,
  // Main memory
  input wire logic mem_accept,
  output logic mem_go,
  output logic [mra_pkg::ADDR_W-1:0] mem_addr,
  output logic [mra_pkg::TAG_W-1:0] mem_tag
);
  import mra_pkg::*;

  function automatic logic mode_clash(input logic v, input logic wr, input logic want);
    mode_clash = v && (wr != want);
  endfunction

  // Queue stages, flow order st1 -> st4 -> st3 -> st2
  logic [1:0] slot_reg, slot_next;
  logic [ADDR_W-1:0] st1_addr_reg, st1_addr_next, st4_addr_reg, st4_addr_next;
  logic [ADDR_W-1:0] st3_addr_reg, st3_addr_next, st2_addr_reg, st2_addr_next;
  logic [TAG_W-1:0] st1_tag_reg, st1_tag_next, st4_tag_reg, st4_tag_next;
  logic [TAG_W-1:0] st3_tag_reg, st3_tag_next, st2_tag_reg, st2_tag_next;
  logic st1_v_reg, st1_v_next, st4_v_reg, st4_v_next, st3_v_reg, st3_v_next;
  logic st1_wr_reg, st1_wr_next, st4_wr_reg, st4_wr_next, st3_wr_reg, st3_wr_next;
  logic acc_reg, acc_next, go_reg, go_next;
  logic tick, acc_hit, grant_re, grant_cp, grant_pp, grant_sw, pp_rw, cp_block;

  // Control state
  mra_swap_t sw_reg, sw_next;
  logic [ADDR_W-1:0] op_hold_reg, op_hold_next, fe_hold_reg, fe_hold_next;
  logic [TAG_W-1:0] op_htag_reg, op_htag_next, fe_htag_reg, fe_htag_next;
  logic op_hwr_reg, op_hwr_next;
  logic [ADDR_W-1:0] stg_addr_reg, stg_addr_next, sw_addr_reg, sw_addr_next;
  logic [TAG_W-1:0] stg_tag_reg, stg_tag_next;
  logic stg_wr_reg, stg_wr_next;
  logic [SWAP_CNT_W-1:0] sw_tag_reg, sw_tag_next;
  logic opp_reg, opp_next, fep_reg, fep_next, creq_reg, creq_next;
  logic sup_reg, sup_next, halt_reg, halt_next, swb_reg, swb_next;
  logic ppg_reg, ppg_next, done_reg, done_next;
  logic load_op, load_fe;

  // Grant decode, only at the slot boundary
  always_comb begin
    tick = ce && (slot_reg == SLOT_LAST);
    acc_hit = acc_reg || mem_accept;
    // Accepted address in st4 never comes back
    grant_re = tick && st3_v_reg;
    cp_block = mode_clash(st1_v_reg, st1_wr_reg, stg_wr_reg) ||
               mode_clash(st4_v_reg, st4_wr_reg, stg_wr_reg);
    grant_cp = tick && !grant_re && creq_reg && !cp_block;
    pp_rw = pp_req && (pp_kind == MRA_KIND_READ || pp_kind == MRA_KIND_WRITE);
    grant_sw = tick && !grant_re && !grant_cp && (sw_reg == MRA_SW_RUN) && !swb_reg;
    grant_pp = tick && !grant_re && !grant_cp && pp_rw && (sw_reg == MRA_SW_IDLE);
  end

  // Queue path
  always_comb begin
    slot_next = slot_reg;
    st1_addr_next = st1_addr_reg;
    st4_addr_next = st4_addr_reg;
    st3_addr_next = st3_addr_reg;
    st2_addr_next = st2_addr_reg;
    st1_tag_next = st1_tag_reg;
    st4_tag_next = st4_tag_reg;
    st3_tag_next = st3_tag_reg;
    st2_tag_next = st2_tag_reg;
    st1_v_next = st1_v_reg;
    st4_v_next = st4_v_reg;
    st3_v_next = st3_v_reg;
    st1_wr_next = st1_wr_reg;
    st4_wr_next = st4_wr_reg;
    st3_wr_next = st3_wr_reg;
    acc_next = acc_reg;
    go_next = 1'b0;
    if (ce) begin
      slot_next = tick ? SLOT_RST : slot_reg + 2'h1;
      // Sticky, so a one-cycle accept anywhere in the slot still counts
      acc_next = acc_reg || mem_accept;
      if (tick) begin
        acc_next = 1'b0;
        st4_addr_next = st1_addr_reg;
        st4_tag_next = st1_tag_reg;
        st4_v_next = st1_v_reg;
        st4_wr_next = st1_wr_reg;
        st3_addr_next = st4_addr_reg;
        st3_tag_next = st4_tag_reg;
        st3_v_next = st4_v_reg && !acc_hit;
        st3_wr_next = st4_wr_reg;
        // Address and tag delay only, no valid bit kept here
        st2_addr_next = st3_addr_reg;
        st2_tag_next = st3_tag_reg;
        // Four-way input select, steered by grant alone
        if (grant_re) begin
          st1_addr_next = st3_addr_reg;
          st1_tag_next = st3_tag_reg;
          st1_wr_next = st3_wr_reg;
        end else if (grant_cp) begin
          st1_addr_next = stg_addr_reg;
          st1_tag_next = stg_tag_reg;
          st1_wr_next = stg_wr_reg;
        end else if (grant_sw) begin
          st1_addr_next = sw_addr_reg;
          st1_tag_next = TAG_W'(sw_tag_reg);
          st1_wr_next = 1'b0;
        end else if (grant_pp) begin
          st1_addr_next = pp_addr;
          st1_tag_next = pp_tag;
          st1_wr_next = (pp_kind == MRA_KIND_WRITE);
        end
        st1_v_next = grant_re || grant_cp || grant_sw || grant_pp;
        go_next = st1_v_next;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      slot_reg <= SLOT_RST;
      st1_addr_reg <= ADDR_RST;
      st4_addr_reg <= ADDR_RST;
      st3_addr_reg <= ADDR_RST;
      st2_addr_reg <= ADDR_RST;
      st1_tag_reg <= TAG_RST;
      st4_tag_reg <= TAG_RST;
      st3_tag_reg <= TAG_RST;
      st2_tag_reg <= TAG_RST;
      st1_v_reg <= 1'b0;
      st4_v_reg <= 1'b0;
      st3_v_reg <= 1'b0;
      st1_wr_reg <= 1'b0;
      st4_wr_reg <= 1'b0;
      st3_wr_reg <= 1'b0;
      acc_reg <= 1'b0;
      go_reg <= 1'b0;
    end else begin
      slot_reg <= slot_next;
      st1_addr_reg <= st1_addr_next;
      st4_addr_reg <= st4_addr_next;
      st3_addr_reg <= st3_addr_next;
      st2_addr_reg <= st2_addr_next;
      st1_tag_reg <= st1_tag_next;
      st4_tag_reg <= st4_tag_next;
      st3_tag_reg <= st3_tag_next;
      st2_tag_reg <= st2_tag_next;
      st1_v_reg <= st1_v_next;
      st4_v_reg <= st4_v_next;
      st3_v_reg <= st3_v_next;
      st1_wr_reg <= st1_wr_next;
      st4_wr_reg <= st4_wr_next;
      st3_wr_reg <= st3_wr_next;
      acc_reg <= acc_next;
      go_reg <= go_next;
    end
  end

  // Central staging and swap control
  always_comb begin
    sw_next = sw_reg;
    op_hold_next = op_hold_reg;
    op_htag_next = op_htag_reg;
    op_hwr_next = op_hwr_reg;
    fe_hold_next = fe_hold_reg;
    fe_htag_next = fe_htag_reg;
    stg_addr_next = stg_addr_reg;
    stg_tag_next = stg_tag_reg;
    stg_wr_next = stg_wr_reg;
    sw_addr_next = sw_addr_reg;
    sw_tag_next = sw_tag_reg;
    opp_next = opp_reg;
    fep_next = fep_reg;
    creq_next = creq_reg;
    sup_next = sup_reg;
    halt_next = halt_reg;
    swb_next = swb_reg;
    ppg_next = 1'b0;
    done_next = 1'b0;
    load_op = 1'b0;
    load_fe = 1'b0;
    if (ce) begin
      // Granted entry frees staging; a new load is judged from the next cycle
      if (grant_cp) begin
        creq_next = 1'b0;
      end
      // Staging loads only when empty; operand outranks fetch
      load_op = opp_reg && !creq_reg;
      load_fe = fep_reg && !opp_reg && !creq_reg;
      if (load_op || load_fe) begin
        stg_addr_next = (load_op ? op_hold_reg : fe_hold_reg) + relocation_base_register;
        stg_tag_next = load_op ? op_htag_reg : fe_htag_reg;
        stg_wr_next = load_op && op_hwr_reg;
        creq_next = 1'b1;
      end
      if (load_op) begin
        opp_next = 1'b0;
      end
      if (load_fe) begin
        fep_next = 1'b0;
        sup_next = 1'b0;
      end
      // New requests win over the clear above
      if (op_req) begin
        opp_next = 1'b1;
        op_hold_next = op_addr;
        op_htag_next = op_tag;
        op_hwr_next = op_write;
      end
      if (fetch_req) begin
        fep_next = 1'b1;
        fe_hold_next = fetch_addr;
        fe_htag_next = fetch_tag;
      end
      if (return_jump) begin
        sup_next = 1'b1;
      end
      ppg_next = grant_pp;
      case (sw_reg)
        MRA_SW_IDLE: begin
          if (pp_req && pp_kind == MRA_KIND_SWAP) begin
            sw_addr_next = pp_addr;
            sw_tag_next = SWAP_TAG_RST;
            halt_next = 1'b1;
            ppg_next = 1'b1;
            sw_next = MRA_SW_HALT;
          end
        end
        MRA_SW_HALT: begin
          // Counters stay put until the processor confirms halted
          if (cpu_halted) begin
            swb_next = 1'b0;
            sw_next = MRA_SW_RUN;
          end
        end
        MRA_SW_RUN: begin
          if (grant_sw) begin
            swb_next = 1'b1;
          end
          // One swap address in flight, so any accept belongs to it
          if (tick && st4_v_reg && acc_hit) begin
            sw_addr_next = sw_addr_reg + 18'h00001;
            sw_tag_next = sw_tag_reg + 5'h01;
            swb_next = 1'b0;
            if (sw_tag_reg + 5'h01 == SWAP_LAST) begin
              done_next = 1'b1;
              halt_next = 1'b0;
              sup_next = 1'b1;
              sw_next = MRA_SW_IDLE;
            end
          end
        end
        default: sw_next = MRA_SW_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sw_reg <= MRA_SW_IDLE;
      op_hold_reg <= ADDR_RST;
      op_htag_reg <= TAG_RST;
      op_hwr_reg <= 1'b0;
      fe_hold_reg <= ADDR_RST;
      fe_htag_reg <= TAG_RST;
      stg_addr_reg <= ADDR_RST;
      stg_tag_reg <= TAG_RST;
      stg_wr_reg <= 1'b0;
      sw_addr_reg <= ADDR_RST;
      sw_tag_reg <= SWAP_TAG_RST;
      opp_reg <= 1'b0;
      fep_reg <= 1'b0;
      creq_reg <= 1'b0;
      sup_reg <= 1'b0;
      halt_reg <= 1'b0;
      swb_reg <= 1'b0;
      ppg_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      sw_reg <= sw_next;
      op_hold_reg <= op_hold_next;
      op_htag_reg <= op_htag_next;
      op_hwr_reg <= op_hwr_next;
      fe_hold_reg <= fe_hold_next;
      fe_htag_reg <= fe_htag_next;
      stg_addr_reg <= stg_addr_next;
      stg_tag_reg <= stg_tag_next;
      stg_wr_reg <= stg_wr_next;
      sw_addr_reg <= sw_addr_next;
      sw_tag_reg <= sw_tag_next;
      opp_reg <= opp_next;
      fep_reg <= fep_next;
      creq_reg <= creq_next;
      sup_reg <= sup_next;
      halt_reg <= halt_next;
      swb_reg <= swb_next;
      ppg_reg <= ppg_next;
      done_reg <= done_next;
    end
  end

  assign mem_go = go_reg;
  assign mem_addr = st1_addr_reg;
  assign mem_tag = st1_tag_reg;
  assign operand_pending = opp_reg;
  assign fetch_pending = fep_reg;
  assign central_req = creq_reg;
  assign suppress_inc = sup_reg;
  assign cpu_halt = halt_reg;
  assign pp_grant = ppg_reg;
  assign swap_done = done_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_last_accept;
    tick && sw_reg == MRA_SW_RUN && st4_v_reg && acc_hit && sw_tag_reg == 5'h0F;
  endsequence

  a_go_one_slot: assert property (mem_go && ce |=> !mem_go) else $error("go held past one cycle");
  a_reloc_added: assert property (load_op |=> stg_addr_reg == $past(op_hold_reg) + $past(relocation_base_register))
    else $error("staging address not relocated");
  a_recirc_entry: assert property (tick && st3_v_reg |=> st1_v_reg && st1_addr_reg == $past(st3_addr_reg))
    else $error("rejected address not re-offered");
  a_halt_before_run: assert property (sw_reg == MRA_SW_HALT && !cpu_halted |=> sw_reg != MRA_SW_RUN && cpu_halt)
    else $error("swap ran before halt confirmed");
  a_swap_advance: assert property (tick && sw_reg == MRA_SW_RUN && st4_v_reg && acc_hit |=>
    sw_addr_reg == $past(sw_addr_reg) + 18'h00001) else $error("swap address did not advance");
  a_swap_complete: assert property (s_last_accept |=> swap_done ##1 !swap_done && !cpu_halt)
    else $error("swap complete not returned at count 16");
  a_fetch_order: assert property (load_fe |-> !opp_reg && !creq_reg) else $error("fetch loaded over operand");
  a_prio_fixed: assert property (tick && st3_v_reg && central_req |=> central_req)
    else $error("central granted over recirculation");
  a_mode_mixing: assert property (grant_cp |-> (!st1_v_reg || st1_wr_reg == stg_wr_reg) &&
    (!st4_v_reg || st4_wr_reg == stg_wr_reg)) else $error("mixed read and write admitted");
  a_swap_blocks_pp: assert property (sw_reg != MRA_SW_IDLE |=> !pp_grant) else $error("peripheral traffic in swap");
  a_go_with_valid: assert property (mem_go |-> st1_v_reg) else $error("go without valid address");
endmodule
`default_nettype wire

/* File: verification/mra_mem_model.sv */
// Main memory model: accepts or refuses each offered address
`timescale 1ns/1ps
`default_nettype none
module mra_mem_model (
  // Clock
  input wire logic core_clk,
  // Arbiter side
  input wire logic mem_go,
  output logic mem_accept,
  // Bench control: refuse the offer seen while high
  input wire logic refuse
);
  logic [4:0] ok_pipe = 5'h00;
  // Busy bank: a refused offer simply gets no accept
  always @(posedge core_clk) begin
    ok_pipe <= {ok_pipe[3:0], (mem_go === 1'h1) & ~refuse};
  end
  // Accept mid-way through the slot after the offer, one cycle only
  always @(negedge core_clk) begin
    mem_accept <= ok_pipe[4];
  end
endmodule
`default_nettype wire

/* File: verification/tb_memory_request_arbiter.sv */
// Self-checking testbench for the memory request arbiter
`timescale 1ns/1ps
`default_nettype none
module tb_memory_request_arbiter;
  import mra_pkg::*;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic ce = 1'h1;
  logic op_req = 1'h0, op_write = 1'h0, fetch_req = 1'h0, return_jump = 1'h0;
  logic cpu_halted = 1'h0, pp_req = 1'h0, refuse = 1'h0;
  logic [ADDR_W-1:0] op_addr = 18'h00000, fetch_addr = 18'h00000, pp_addr = 18'h00000;
  logic [ADDR_W-1:0] relocation_base_register = 18'h00000, exp_a, mem_addr;
  logic [TAG_W-1:0] op_tag = 6'h00, fetch_tag = 6'h00, pp_tag = 6'h00, mem_tag;
  logic [1:0] pp_kind = 2'h3;
  logic operand_pending, fetch_pending, central_req, suppress_inc, cpu_halt;
  logic pp_grant, swap_done, mem_accept, mem_go;
  int fail_count = 0, tests_run = 0, cyc = 0, grants = 0, dones = 0, i, j, k;
  int go_t[$];
  logic [ADDR_W-1:0] go_a[$];
  logic [TAG_W-1:0] go_g[$];

  mra_arbiter uut (.core_clk(core_clk), .rst(rst), .ce(ce), .op_req(op_req), .op_addr(op_addr),
    .op_tag(op_tag), .op_write(op_write), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_tag(fetch_tag), .return_jump(return_jump), .cpu_halted(cpu_halted),
    .relocation_base_register(relocation_base_register), .operand_pending(operand_pending),
    .fetch_pending(fetch_pending), .central_req(central_req), .suppress_inc(suppress_inc),
    .cpu_halt(cpu_halt), .pp_req(pp_req), .pp_addr(pp_addr), .pp_kind(pp_kind), .pp_tag(pp_tag),
    .pp_grant(pp_grant), .swap_done(swap_done), .mem_accept(mem_accept), .mem_go(mem_go),
    .mem_addr(mem_addr), .mem_tag(mem_tag));
  mra_mem_model mem (.core_clk(core_clk), .mem_go(mem_go), .mem_accept(mem_accept), .refuse(refuse));

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  // Log every offer to memory with its cycle number
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (mem_go === 1'h1) begin
      go_t.push_back(cyc);
      go_a.push_back(mem_addr);
      go_g.push_back(mem_tag);
    end
    if (pp_grant === 1'h1) grants <= grants + 1;
    if (swap_done === 1'h1) dones <= dones + 1;
    if (cyc == 4000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t ns %s: got %0h want %0h", $time, what, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Bounded wait until n offers have been logged
  task automatic wait_go(input int n);
    k = 0;
    while (go_t.size() < n && k < 300) begin
      tick(1);
      k++;
    end
  endtask
  task automatic clear_q;
    go_t.delete();
    go_a.delete();
    go_g.delete();
  endtask
  task automatic op(input logic [ADDR_W-1:0] a, input logic [TAG_W-1:0] t, input logic wr);
    op_addr = a;
    op_tag = t;
    op_write = wr;
    op_req = 1'h1;
    tick(1);
    op_req = 1'h0;
  endtask
  // Every peripheral address carries its kind; held until taken
  task automatic pp_request(input logic [ADDR_W-1:0] a, input logic [1:0] kd, input logic [TAG_W-1:0] t);
    pp_addr = a;
    pp_kind = kd;
    pp_tag = t;
    pp_req = 1'h1;
    k = 0;
    while (pp_grant !== 1'h1 && k < 300) begin
      tick(1);
      k++;
    end
    pp_req = 1'h0;
    pp_kind = 2'h3;
  endtask
  task automatic conclude;
    $display("Counts: %0d compares, %0d mismatches", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    tick(6);
    rst = 1'h0;
    check({mem_go, cpu_halt, pp_grant, swap_done, central_req, suppress_inc}, 0, "idle outputs");
    return_jump = 1'h1;
    tick(1);
    return_jump = 1'h0;
    check(suppress_inc, 1, "suppress set");
    $display("Test reset and return jump done");
    // Central operand, relocated
    relocation_base_register = 18'h01000;
    op(18'h00234, 6'h05, 1'h0);
    check(operand_pending, 1, "operand pending");
    tick(1);
    check(central_req, 1, "central request");
    wait_go(1);
    tick(20);
    check(go_a[0], 18'h01234, "relocated addr");
    check(go_g[0], 6'h05, "operand tag");
    check(go_t.size(), 1, "accepted not reissued");
    $display("Test operand done");
    // Fetch refused once by a busy bank
    clear_q();
    refuse = 1'h1;
    fetch_addr = 18'h00100;
    fetch_tag = 6'h21;
    fetch_req = 1'h1;
    tick(1);
    fetch_req = 1'h0;
    check(fetch_pending, 1, "fetch pending");
    wait_go(1);
    refuse = 1'h0;
    wait_go(2);
    tick(20);
    check(go_t.size(), 2, "one retry only");
    check(go_t[1] - go_t[0], 12, "retry spacing");
    check({go_a[1], go_g[1]}, {18'h01100, 6'h21}, "retry addr tag");
    check(suppress_inc, 0, "suppress cleared by fetch");
    $display("Test recirculation done");
    // Central and peripheral contend in the same slot
    clear_q();
    op(18'h00010, 6'h07, 1'h0);
    tick(1);
    pp_request(18'h03000, MRA_KIND_READ, 6'h30);
    wait_go(2);
    check({go_a[0], go_a[1]}, {18'h01010, 18'h03000}, "central before peripheral");
    check(go_t[1] - go_t[0] >= 4, 1, "one offer per slot");
    $display("Test priority done");
    // Read must wait behind a refused write
    tick(20);
    clear_q();
    refuse = 1'h1;
    op(18'h00040, 6'h08, 1'h1);
    wait_go(1);
    refuse = 1'h0;
    op(18'h00041, 6'h09, 1'h0);
    wait_go(3);
    check({go_a[1], go_a[2]}, {18'h01040, 18'h01041}, "no mixed modes");
    $display("Test mode clash done");
    // Context swap with one refused step and a blocked read
    tick(20);
    clear_q();
    pp_request(18'h02000, MRA_KIND_SWAP, 6'h00);
    tick(1);
    check(cpu_halt, 1, "halt requested");
    pp_addr = 18'h03F00;
    pp_kind = MRA_KIND_READ;
    pp_tag = 6'h11;
    pp_req = 1'h1;
    tick(12);
    check(go_t.size(), 0, "waits for halted");
    refuse = 1'h1;
    cpu_halted = 1'h1;
    wait_go(1);
    refuse = 1'h0;
    k = 0;
    while (dones == 0 && k < 600) begin
      tick(1);
      k++;
    end
    check(go_t.size(), 17, "swap offer count");
    for (i = 0; i < 17; i++) begin
      j = (i == 0) ? 0 : i - 1;
      exp_a = 18'h02000 + 18'(j);
      check({go_a[i], go_g[i]}, {exp_a, 6'(j)}, "swap step");
    end
    tick(1);
    check({cpu_halt, suppress_inc}, 2'h1, "swap end flags");
    k = 0;
    while (pp_grant !== 1'h1 && k < 100) begin
      tick(1);
      k++;
    end
    pp_req = 1'h0;
    cpu_halted = 1'h0;
    wait_go(18);
    check(go_a[17], 18'h03F00, "read after swap");
    check(dones, 1, "single swap done");
    $display("Test swap done");
    conclude();
  end
endmodule
`default_nettype wire
